// File: src/mark_sync.sv
// Two-stage synchroniser and glitch filter for the transducer input
`timescale 1ns/100ps
module mark_sync
	import sector_timing_pkg::*;
#(
	parameter int FILT = MARK_FILT_CYC
) (
	input  wire logic hclk,       // System clock
	input  wire logic hresetn,    // Async reset, low
	input  wire logic mark_pin_n, // Raw transducer, low in a slot
	output logic      mark_start  // One pulse at a clean mark start
);

	logic       meta_r;
	logic       sync_r;
	logic       level_r;
	logic [7:0] stable_r;

	wire logic differs = (sync_r != level_r);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r   <= 1'b0;
			sync_r   <= 1'b0;
			level_r  <= 1'b0;
			stable_r <= 8'h00;
			mark_start <= 1'b0;
		end else begin
			meta_r     <= ~mark_pin_n;
			sync_r     <= meta_r;
			mark_start <= 1'b0;
			// Spikes shorter than FILT cycles never flip the level
			if (!differs) begin
				stable_r <= 8'h00;
			end else if (stable_r == 8'(FILT - 1)) begin
				stable_r   <= 8'h00;
				level_r    <= sync_r;
				mark_start <= sync_r;
			end else begin
				stable_r <= stable_r + 8'h01;
			end
		end
	end

endmodule : mark_sync

// File: src/oneshot_timer.sv
// Retriggerable one-shot realised as a down counter
`timescale 1ns/100ps
module oneshot_timer
	import sector_timing_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic hclk,     // System clock
	input wire logic hresetn,  // Async reset, low
	timer_if.timer   t         // Start, length, busy, expire
);

	logic [W-1:0] cnt_r;
	logic         busy_r;
	logic         expire_r;

	// Zero length would wrap to a full count; treat it as one cycle
	wire logic [W-1:0] len_eff = (t.length == '0) ? {{(W-1){1'b0}}, 1'b1} : t.length;
	wire logic         last    = (cnt_r == {{(W-1){1'b0}}, 1'b1});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r    <= '0;
			busy_r   <= 1'b0;
			expire_r <= 1'b0;
		end else begin
			expire_r <= 1'b0;
			if (t.start) begin
				cnt_r  <= len_eff;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 1'b1;
				if (last) begin
					busy_r   <= 1'b0;
					expire_r <= 1'b1;
				end
			end
		end
	end

	assign t.busy   = busy_r;
	assign t.expire = expire_r;

endmodule : oneshot_timer

// File: src/sector_index_pulse_timing.sv
// Sector/index pulse timing with AHB-Lite register access
`timescale 1ns/100ps
module sector_index_pulse_timing
	import sector_timing_pkg::*;
#(
	parameter int INDEX_WIN_DEF  = INDEX_WIN_CYC,  // Separation window, cycles
	parameter int SECTOR_DLY_DEF = SECTOR_DLY_CYC, // Sector delay after reset, cycles
	parameter int MARK_FILT      = MARK_FILT_CYC   // Deglitch length, cycles
) (
	input  wire logic        hclk,              // System clock, 50 MHz
	input  wire logic        hresetn,           // Async reset, low
	input  wire logic        hsel,              // Slave select
	input  wire logic [31:0] haddr,             // Byte address
	input  wire logic [1:0]  htrans,            // Transfer type
	input  wire logic        hwrite,            // Write when high
	input  wire logic [2:0]  hsize,             // Transfer size
	input  wire logic [31:0] hwdata,            // Write data
	input  wire logic        hready,            // Bus ready
	output logic      [31:0] hrdata,            // Read data
	output logic             hreadyout,         // Slave ready
	output logic             hresp,             // Always OKAY
	input  wire logic        mark_pin_n,        // Transducer, low in a slot
	input  wire logic        sel_ready,         // Drive selected and ready
	output logic             sector_pulse_oe_n, // Pulls sector line low
	output logic             index_pulse_oe_n,  // Pulls index line low
	output logic      [3:0]  sector_addr_o,     // Sector address value
	output logic             sector_addr_oe_n,  // Drives sector address
	output logic             irq                // Level interrupt
);

	timer_if #(.W(CNT_W)) dly_t ();
	timer_if #(.W(CNT_W)) mark_t ();
	timer_if #(.W(CNT_W)) win_t ();

	logic mark_start;

	mark_sync #(
		.FILT       (MARK_FILT)
	) u_sync (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.mark_pin_n (mark_pin_n),
		.mark_start (mark_start)
	);

	oneshot_timer #(.W(CNT_W)) u_sector_delay (
		.hclk    (hclk),
		.hresetn (hresetn),
		.t       (dly_t)
	);

	oneshot_timer #(.W(CNT_W)) u_mark_generator (
		.hclk    (hclk),
		.hresetn (hresetn),
		.t       (mark_t)
	);

	oneshot_timer #(.W(CNT_W)) u_index_window (
		.hclk    (hclk),
		.hresetn (hresetn),
		.t       (win_t)
	);

	// Register state
	logic [31:0]      ctrl_r;
	logic [CNT_W-1:0] sector_dly_r;
	logic [CNT_W-1:0] mark_width_r;
	logic [CNT_W-1:0] index_win_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_status_nxt;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [15:0]      rev_count_r;

	// Timing state
	mark_state_t      mark_state_r;
	mark_state_t      mark_state_nxt;
	logic [3:0]       sector_cnt_r;
	logic [3:0]       sector_cnt_nxt;
	logic             reset_flag_r;
	logic             reset_flag_nxt;

	// Output flops
	logic             sector_oe_n_r;
	logic             index_oe_n_r;
	logic [3:0]       addr_out_r;
	logic             addr_oe_n_r;
	logic             irq_r;

	// Bus state
	logic             wr_pend_r;
	logic             rd_pend_r;
	logic [7:0]       addr_r;
	logic [31:0]      hrdata_r;

	// ------------------------------------------------------------------
	// Mark path
	// ------------------------------------------------------------------
	wire logic enabled   = ctrl_r[CTRL_ENABLE];
	wire logic mark_fire = dly_t.expire;
	wire logic is_index  = mark_fire & win_t.busy;
	wire logic is_sector = mark_fire & ~win_t.busy;
	wire logic mark_end  = mark_t.expire & ~mark_fire;
	wire logic sector_end = mark_end & (mark_state_r == MK_SECTOR);

	// Each clean mark restarts the trim delay; disabled block ignores marks
	assign dly_t.start   = mark_start & enabled;
	assign dly_t.length  = sector_dly_r;
	assign mark_t.start  = mark_fire;
	assign mark_t.length = mark_width_r;
	assign win_t.start   = mark_fire;
	assign win_t.length  = index_win_r;

	// A thirteenth sector with no index between means the index slot was lost
	wire logic missed = is_sector & ~reset_flag_r & (sector_cnt_r == LAST_SECTOR);

	always_comb begin
		mark_state_nxt = mark_state_r;
		if (is_index) begin
			mark_state_nxt = MK_INDEX;
		end else if (is_sector) begin
			mark_state_nxt = MK_SECTOR;
		end else if (mark_end) begin
			mark_state_nxt = MK_IDLE;
		end
	end

	always_comb begin
		sector_cnt_nxt = sector_cnt_r;
		if (is_sector) begin
			if (reset_flag_r) begin
				sector_cnt_nxt = 4'h0;
			end else begin
				sector_cnt_nxt = sector_cnt_r + 4'h1;
			end
		end
	end

	// Setting by an index wins over the clear at a sector trailing edge
	always_comb begin
		reset_flag_nxt = reset_flag_r;
		if (sector_end) begin
			reset_flag_nxt = 1'b0;
		end
		if (is_index) begin
			reset_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mark_state_r <= MK_IDLE;
			sector_cnt_r <= 4'h0;
			reset_flag_r <= 1'b0;
			rev_count_r  <= 16'h0000;
		end else begin
			mark_state_r <= mark_state_nxt;
			sector_cnt_r <= sector_cnt_nxt;
			reset_flag_r <= reset_flag_nxt;
			if (is_index) begin
				rev_count_r <= rev_count_r + 16'h0001;
			end
		end
	end

	// Interface lines only while selected and ready; internal state runs regardless
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sector_oe_n_r <= 1'b1;
			index_oe_n_r  <= 1'b1;
			addr_out_r    <= 4'h0;
			addr_oe_n_r   <= 1'b1;
		end else begin
			sector_oe_n_r <= ~(sel_ready & (mark_state_nxt == MK_SECTOR));
			index_oe_n_r  <= ~(sel_ready & (mark_state_nxt == MK_INDEX));
			addr_out_r    <= sector_cnt_nxt;
			addr_oe_n_r   <= ~sel_ready;
		end
	end

	assign sector_pulse_oe_n = sector_oe_n_r;
	assign index_pulse_oe_n  = index_oe_n_r;
	assign sector_addr_o     = addr_out_r;
	assign sector_addr_oe_n  = addr_oe_n_r;

	// ------------------------------------------------------------------
	// AHB-Lite slave: writes without wait, reads with one wait state
	// ------------------------------------------------------------------
	wire logic addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end else begin
			if (addr_phase) begin
				wr_pend_r <= hwrite;
				rd_pend_r <= ~hwrite;
				addr_r    <= {haddr[7:2], 2'b00};
			end else if (hready) begin
				wr_pend_r <= 1'b0;
				rd_pend_r <= 1'b0;
			end else begin
				rd_pend_r <= 1'b0;
			end
		end
	end

	wire logic wr_ctrl      = wr_pend_r & (addr_r == OFS_CTRL);
	wire logic wr_delay     = wr_pend_r & (addr_r == OFS_SECTOR_DLY);
	wire logic wr_width     = wr_pend_r & (addr_r == OFS_MARK_WIDTH);
	wire logic wr_window    = wr_pend_r & (addr_r == OFS_INDEX_WIN);
	wire logic wr_irq_stat  = wr_pend_r & (addr_r == OFS_IRQ_STATUS);
	wire logic wr_irq_mask  = wr_pend_r & (addr_r == OFS_IRQ_MASK);

	wire logic [IRQ_W-1:0] irq_events = {missed, is_index, is_sector};

	// Write-one clears; a new event in the same cycle stays set
	always_comb begin
		irq_status_nxt = irq_status_r;
		if (wr_irq_stat) begin
			irq_status_nxt = irq_status_r & ~hwdata[IRQ_W-1:0];
		end
		irq_status_nxt = irq_status_nxt | irq_events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r       <= CTRL_RST;
			sector_dly_r <= CNT_W'(SECTOR_DLY_DEF);
			mark_width_r <= CNT_W'(MARK_WIDTH_CYC);
			index_win_r  <= CNT_W'(INDEX_WIN_DEF);
			irq_mask_r   <= MASK_RST;
			irq_status_r <= '0;
			irq_r        <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl_r <= {31'h0000_0000, hwdata[CTRL_ENABLE]};
			if (wr_delay) sector_dly_r <= hwdata[CNT_W-1:0];
			if (wr_width) mark_width_r <= hwdata[CNT_W-1:0];
			if (wr_window) index_win_r <= hwdata[CNT_W-1:0];
			if (wr_irq_mask) irq_mask_r <= hwdata[IRQ_W-1:0];
			irq_status_r <= irq_status_nxt;
			irq_r        <= |(irq_status_nxt & irq_mask_r);
		end
	end

	wire logic [31:0] status_word = {24'h00_0000, mark_t.busy, sel_ready,
		win_t.busy, reset_flag_r, sector_cnt_r};

	function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
		widen = {{(32-CNT_W){1'b0}}, v};
	endfunction : widen

	wire logic [31:0] rd_mux =
		(addr_r == OFS_CTRL)       ? ctrl_r :
		(addr_r == OFS_STATUS)     ? status_word :
		(addr_r == OFS_SECTOR_DLY) ? widen(sector_dly_r) :
		(addr_r == OFS_MARK_WIDTH) ? widen(mark_width_r) :
		(addr_r == OFS_INDEX_WIN)  ? widen(index_win_r) :
		(addr_r == OFS_IRQ_STATUS) ? {29'h0000_0000, irq_status_r} :
		(addr_r == OFS_IRQ_MASK)   ? {29'h0000_0000, irq_mask_r} :
		(addr_r == OFS_REV_COUNT)  ? {16'h0000, rev_count_r} :
		32'h0000_0000;

	// Read data is sampled in the wait cycle so a write just before is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_mux;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = ~rd_pend_r;
	assign hresp     = HRESP_OKAY;
	assign irq       = irq_r;

endmodule : sector_index_pulse_timing

// File: src/sector_timing_pkg.sv
// Constants, types and register map of the sector/index pulse timing block
package sector_timing_pkg;

	localparam int CLK_HZ          = 50_000_000;
	localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int CNT_W           = 20;
	localparam int SECTORS_PER_REV = 12;

	// Times in microseconds, counts derived from the clock rate; the mark filter is given in cycles
	localparam int INDEX_WIN_US    = 2000;
	localparam int INDEX_WIN_CYC   = INDEX_WIN_US * CYC_PER_US;
	localparam int SECTOR_DLY_US   = 100;
	localparam int SECTOR_DLY_CYC  = SECTOR_DLY_US * CYC_PER_US;
	localparam int MARK_WIDTH_US   = 10;
	localparam int MARK_WIDTH_CYC  = MARK_WIDTH_US * CYC_PER_US;
	localparam int MARK_FILT_CYC   = 4;

	localparam logic [3:0] LAST_SECTOR = 4'(SECTORS_PER_REV - 1);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_SECTOR_DLY = 8'h08;
	localparam logic [7:0] OFS_MARK_WIDTH = 8'h0c;
	localparam logic [7:0] OFS_INDEX_WIN  = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
	localparam logic [7:0] OFS_REV_COUNT  = 8'h1c;

	// Field positions
	localparam int CTRL_ENABLE    = 0;
	localparam int ST_SECTOR_LSB  = 0;
	localparam int ST_RESET_FLAG  = 4;
	localparam int ST_WINDOW      = 5;
	localparam int ST_SEL_READY   = 6;
	localparam int ST_MARK_BUSY   = 7;
	localparam int IRQ_SECTOR     = 0;
	localparam int IRQ_INDEX      = 1;
	localparam int IRQ_MISSED     = 2;
	localparam int IRQ_W          = 3;

	// Values after reset
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		MK_IDLE,
		MK_SECTOR,
		MK_INDEX
	} mark_state_t;

endpackage : sector_timing_pkg

// File: src/timer_if.sv
// Start/expire handshake between the block and one of its one-shot counters
`timescale 1ns/100ps
interface timer_if #(parameter int W = 20);
	logic         start;
	logic [W-1:0] length;
	logic         busy;
	logic         expire;

	modport ctrl  (output start, output length, input busy, input expire);
	modport timer (input start, input length, output busy, output expire);
endinterface : timer_if

// File: tb/drive_ctrl_model.sv
// Host controller model watching the pulled-up sector and index lines
`timescale 1ns/100ps
module drive_ctrl_model (
	input  wire logic       hclk,        // Clock
	input  wire logic       want_sel,    // Select request
	input  wire logic       sector_line, // Sector line level
	input  wire logic       index_line,  // Index line level
	input  wire logic [3:0] addr_bus,    // Address bus level
	output logic            sel_ready,   // Selected and ready
	output int              sec_cnt,     // Sector pulses seen
	output int              idx_cnt,     // Index pulses seen
	output logic      [3:0] last_addr    // Address at last sector pulse
);
	logic sec_prev_r = 1'b1;
	logic idx_prev_r = 1'b1;
	initial begin
		sel_ready = 1'b0;
		sec_cnt   = 0;
		idx_cnt   = 0;
		last_addr = 4'h0;
	end
	always @(posedge hclk) begin
		sel_ready  <= want_sel;
		sec_prev_r <= sector_line;
		idx_prev_r <= index_line;
		if (sec_prev_r && !sector_line) begin
			sec_cnt   <= sec_cnt + 1;
			last_addr <= addr_bus;
		end
		if (idx_prev_r && !index_line)
			idx_cnt <= idx_cnt + 1;
	end
endmodule : drive_ctrl_model

// File: tb/sector_index_pulse_timing_tb.sv
// Self-checking bench for the sector/index pulse timing block
`timescale 1ns/100ps
module sector_index_pulse_timing_tb;
	import sector_timing_pkg::*;
	localparam int WIN = 200;
	localparam int DLY = 20;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, irq, sel_ready, sp_oe_n, ip_oe_n, sa_oe_n;
	logic        mark_pin_n = 1'b1;
	logic        want_sel = 1'b0;
	logic [3:0]  sa_o, last_addr;
	int          sec_cnt, idx_cnt;
	int          err_count = 0;
	int          cmp_count = 0;
	// Lines are pulled up, so a released bus reads all ones
	wire [3:0]   addr_bus = sa_oe_n ? 4'hf : sa_o;

	always #10 hclk = ~hclk;

	sector_index_pulse_timing #(.INDEX_WIN_DEF(WIN), .SECTOR_DLY_DEF(DLY), .MARK_FILT(4))
	sector_index_pulse_timing_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mark_pin_n(mark_pin_n),
		.sel_ready(sel_ready), .sector_pulse_oe_n(sp_oe_n), .index_pulse_oe_n(ip_oe_n),
		.sector_addr_o(sa_o), .sector_addr_oe_n(sa_oe_n), .irq(irq)
	);
	drive_ctrl_model drive_ctrl_model_inst (
		.hclk(hclk), .want_sel(want_sel), .sector_line(sp_oe_n), .index_line(ip_oe_n),
		.addr_bus(addr_bus), .sel_ready(sel_ready), .sec_cnt(sec_cnt), .idx_cnt(idx_cnt),
		.last_addr(last_addr)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Entered just after a rising edge; returns at the edge that ends the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr  <= {24'h00_0000, a};
		do @(posedge hclk);
		while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0000_0000, x);
		chk(x, exp);
	endtask : rd_chk

	task automatic mark(input int gap);
		mark_pin_n <= 1'b0;
		repeat (8) @(posedge hclk);
		mark_pin_n <= 1'b1;
		repeat (gap - 8) @(posedge hclk);
	endtask : mark

	task automatic t_regs();
		rd_chk(OFS_CTRL, CTRL_RST);
		rd_chk(OFS_SECTOR_DLY, 32'h0000_0014);
		rd_chk(OFS_INDEX_WIN, 32'h0000_00c8);
		rd_chk(OFS_MARK_WIDTH, 32'h0000_01f4);
		rd_chk(OFS_IRQ_MASK, 32'h0000_0000);
		rd_chk(OFS_IRQ_STATUS, 32'h0000_0000);
		wr(8'h20, 32'hffff_ffff);
		rd_chk(8'h20, 32'h0000_0000);
		wr(OFS_MARK_WIDTH, 32'h0000_000a);
		rd_chk(OFS_MARK_WIDTH, 32'h0000_000a);
	endtask : t_regs

	// Twelve sectors, then the index mark shortly after the last one
	task automatic t_rev(input logic s);
		int s0;
		int i0;
		want_sel <= s;
		s0 = sec_cnt;
		i0 = idx_cnt;
		for (int k = 0; k < SECTORS_PER_REV; k++) begin
			mark(k == SECTORS_PER_REV - 1 ? 100 : 300);
			chk({28'h000_0000, sa_o}, 32'(k));
		end
		mark(300);
		chk({28'h000_0000, sa_o}, 32'h0000_000b);
		chk(32'(sec_cnt - s0), s ? 32'h0000_000c : 32'h0000_0000);
		chk(32'(idx_cnt - i0), {31'h0000_0000, s});
		if (s)
			chk({28'h000_0000, last_addr}, 32'h0000_000b);
		wr(OFS_STATUS, 32'hffff_ffff);
		rd_chk(OFS_STATUS, {24'h00_0000, 1'b0, s, 1'b0, 1'b1, 4'hb});
	endtask : t_rev

	task automatic t_irq();
		rd_chk(OFS_REV_COUNT, 32'h0000_0003);
		rd_chk(OFS_IRQ_STATUS, 32'h0000_0003);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(OFS_IRQ_STATUS, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		rd_chk(OFS_IRQ_STATUS, 32'h0000_0001);
	endtask : t_irq

	// Cycles from mark start to the sector line going low
	task automatic timed(output int n);
		n = 0;
		mark_pin_n <= 1'b0;
		while (sp_oe_n !== 1'b0) begin
			@(posedge hclk);
			n++;
			if (n == 8)
				mark_pin_n <= 1'b1;
		end
		repeat (300) @(posedge hclk);
	endtask : timed

	task automatic t_dly();
		int a;
		int b;
		want_sel <= 1'b1;
		timed(a);
		wr(OFS_SECTOR_DLY, 32'h0000_003c);
		timed(b);
		chk(32'(b - a), 32'h0000_0028);
	endtask : t_dly

	// Eleven sectors with no index: the count runs past eleven, lost index flagged
	task automatic t_miss();
		for (int k = 0; k < 11; k++) begin
			mark(300);
		end
		chk({28'h000_0000, sa_o}, 32'h0000_000c);
		rd_chk(OFS_IRQ_STATUS, 32'h0000_0005);
	endtask : t_miss

	task automatic test_done();
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		// Prime: one sector, then an index to arm the counter clear
		mark(100);
		mark(300);
		t_rev(1'b1);
		t_rev(1'b0);
		t_irq();
		t_dly();
		t_miss();
		test_done();
	end
endmodule : sector_index_pulse_timing_tb

// File: tb/sit_checker.sv
// Port assertions for the sector/index pulse timing block
`timescale 1ns/100ps
module sit_checker
	import sector_timing_pkg::*;
#(
	parameter int INDEX_WIN_DEF  = INDEX_WIN_CYC,
	parameter int SECTOR_DLY_DEF = SECTOR_DLY_CYC,
	parameter int MARK_FILT      = MARK_FILT_CYC
) (
	input wire logic        hclk,              // Clock
	input wire logic        hresetn,           // Reset
	input wire logic        hsel,              // Select
	input wire logic [31:0] haddr,             // Address
	input wire logic [1:0]  htrans,            // Type
	input wire logic        hwrite,            // Write
	input wire logic [2:0]  hsize,             // Size
	input wire logic [31:0] hwdata,            // Wdata
	input wire logic        hready,            // Ready
	input wire logic [31:0] hrdata,            // Rdata
	input wire logic        hreadyout,         // Ready out
	input wire logic        hresp,             // Response
	input wire logic        mark_pin_n,        // Transducer
	input wire logic        sel_ready,         // Selected
	input wire logic        sector_pulse_oe_n, // Sector line
	input wire logic        index_pulse_oe_n,  // Index line
	input wire logic [3:0]  sector_addr_o,     // Address
	input wire logic        sector_addr_oe_n,  // Address drive
	input wire logic        irq                // Interrupt
);
	default clocking dcb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Cycles since the last visible sector pulse began
	logic [19:0] since_r;
	logic        sec_prev_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_r    <= '1;
			sec_prev_r <= 1'b1;
		end else begin
			sec_prev_r <= sector_pulse_oe_n;
			if (sec_prev_r && !sector_pulse_oe_n)
				since_r <= '0;
			else if (since_r != '1)
				since_r <= since_r + 20'h0_0001;
		end
	end

	sequence read_req;
		hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	read_wait_a: assert property (read_req |=> one_wait)
		else $error("read wait state wrong");
	write_nowait_a: assert property (hsel && hready && htrans == HTRANS_NONSEQ && hwrite
		|=> hreadyout)
		else $error("write stalled");
	resp_okay_a: assert property (hresp == HRESP_OKAY)
		else $error("response not okay");
	sector_sel_a: assert property ($fell(sector_pulse_oe_n) |-> $past(sel_ready))
		else $error("sector line pulled while unselected");
	index_sel_a: assert property ($fell(index_pulse_oe_n) |-> $past(sel_ready))
		else $error("index line pulled while unselected");
	addr_drive_a: assert property (sector_addr_oe_n == !$past(sel_ready))
		else $error("address drive does not follow select");
	one_kind_a: assert property (!(!sector_pulse_oe_n && !index_pulse_oe_n))
		else $error("sector and index pulses together");
	sector_step_a: assert property ($fell(sector_pulse_oe_n)
		|-> sector_addr_o == $past(sector_addr_o) + 4'h1 || sector_addr_o == 4'h0)
		else $error("sector count step wrong");
	index_hold_a: assert property ($fell(index_pulse_oe_n) |-> $stable(sector_addr_o))
		else $error("index pulse moved the count");
	index_window_a: assert property ($fell(index_pulse_oe_n)
		|-> since_r <= 20'(INDEX_WIN_DEF))
		else $error("index pulse outside window");
endmodule : sit_checker

bind sector_index_pulse_timing sit_checker #(.INDEX_WIN_DEF(INDEX_WIN_DEF),
	.SECTOR_DLY_DEF(SECTOR_DLY_DEF), .MARK_FILT(MARK_FILT)) sit_checker_inst (.*);
